// [logic/card_status.sv]
// Purpose: Status flags and status byte of one card
// Assumes: Card inputs are on the same clock
// Notes: A set in the cycle of a read clear wins
`timescale 1ns/10ps
`default_nettype none
`include "cardport_map.svh"
module card_status
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic init,
   input wire logic read_done,
   input wire cardport_pkg::card_in_s card_in,
   output logic [7:0] status,
   output logic irq_req
);
   import cardport_pkg::*;

   card_state_s st_r;
   card_state_s st_nxt;
   logic pres_edge;

   always_comb
   begin
      st_nxt = st_r;
      pres_edge = card_in.present ^ st_r.pres_prev;
      st_nxt.pres_prev = card_in.present;
      if (read_done)
      begin
         // Read clears the sticky flags
         st_nxt.presence_change_flag = 1'b0;
         st_nxt.supply_fault_flag = 1'b0;
         st_nxt.overload_flag = 1'b0;
         st_nxt.mute_flag = 1'b0;
         st_nxt.early_flag = 1'b0;
      end
      if (pres_edge)
         st_nxt.presence_change_flag = 1'b1;
      if (card_in.overload_evt)
         st_nxt.overload_flag = 1'b1;
      if (card_in.mute_evt)
         st_nxt.mute_flag = 1'b1;
      if (card_in.early_evt)
         st_nxt.early_flag = 1'b1;
      if (init)
      begin
         // Supervisor active: defaults, fault flag set
         st_nxt.presence_change_flag = 1'b0; // R3
         st_nxt.overload_flag = 1'b0;
         st_nxt.mute_flag = 1'b0;
         st_nxt.early_flag = 1'b0;
         st_nxt.supply_fault_flag = 1'b1; // R1 R23
      end
      st_nxt.status = `CP_STATUS_RESET;
      st_nxt.status[`CP_ST_PRESENT] = card_in.present;
      st_nxt.status[`CP_ST_PRES_CHANGE] = st_nxt.presence_change_flag;
      st_nxt.status[`CP_ST_IO_LEVEL] = card_in.io_level;
      st_nxt.status[`CP_ST_SUPPLY_FAULT] = st_nxt.supply_fault_flag;
      st_nxt.status[`CP_ST_OVERLOAD] = st_nxt.overload_flag;
      st_nxt.status[`CP_ST_MUTE] = st_nxt.mute_flag;
      st_nxt.status[`CP_ST_EARLY] = st_nxt.early_flag;
      st_nxt.status[`CP_ST_ACTIVE] = card_in.active;
      // Interrupt request from the four event flags
      st_nxt.irq_req = st_nxt.presence_change_flag | st_nxt.mute_flag
         | st_nxt.early_flag | st_nxt.overload_flag; // R22
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= '0;
         st_r.supply_fault_flag <= 1'b1;
      end
      else if (clk_en)
         st_r <= st_nxt;
   end

   assign status = st_r.status;
   assign irq_req = st_r.irq_req;
endmodule
`default_nettype wire

// [logic/dual_card_i2c_port.sv]
// Purpose: Two-wire slave control port of a dual card interface
// Assumes: SCL, SDA, IRQ, straps, supervisor and drop-out are pins
// Notes: No clock stretching; SCL is sampled, not used as a clock
//
// Behaviour
// (R1) Supervisor active holds the interrupt line low and sets supply fault.
// (R2) Supervisor counts as released once the interrupt line reads high again.
// (R3) Supervisor active returns all internal state to defaults.
// (R4) Supply drop-out forces immediate emergency deactivation of card contacts.
// (R5) Slave works at both 100 kHz and 400 kHz bus rates.
// (R6) Master starts transfers only on an idle bus.
// (R7) SDA stable while SCL high; changes then are bus conditions.
// (R8) SDA falling with SCL high is START and restarts address reception.
// (R9) SDA rising with SCL high is STOP, ends transfer, frees bus.
// (R10) Master frames each transfer with START and STOP, one pulse per bit.
// (R11) Bytes of eight bits, each followed by a ninth acknowledge bit.
// (R12) Addressed slave receiver acknowledges every byte by pulling SDA low.
// (R13) Master receiver acknowledges every byte except the last.
// (R14) Acknowledger holds SDA low through the whole acknowledge high phase.
// (R15) On a missing master acknowledge the slave releases SDA high.
// (R16) Read keeps returning bytes while the master acknowledges.
// (R17) Two addresses, bit 3 selects card; 40H/48H with straps low.
// (R18) Bits 7..4 are 0100; bits 2 and 1 follow the straps.
// (R19) Address bit 0 one means read, zero means write.
// (R20) Write is address, acknowledge, control byte, acknowledge, STOP.
// (R21) Read returns the selected card status byte right after address.
// (R22) Interrupt low while any event flag set, released after status read.
// (R23) Supply fault stays set after power-on until status is read.
// (R24) Unmatched address gets no acknowledge; bus ignored until next START.
// (R25) SCL and SDA are synchronised before edge and condition detection.
`timescale 1ns/10ps
`default_nettype none
`include "cardport_map.svh"
module dual_card_i2c_port
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   input wire logic irq_in,
   output logic irq_out,
   output logic irq_oe_n,
   input wire logic addr_strap_low,
   input wire logic addr_strap_high,
   input wire logic supervisor_active,
   input wire logic supply_dropout,
   input wire cardport_pkg::card_in_s [1:0] card_in,
   output cardport_pkg::ctrl_out_s [1:0] card_ctrl,
   output logic supervisor_released,
   output logic emergency_deact
);
   import cardport_pkg::*;

   port_state_s st_r;
   port_state_s st_nxt;
   logic [6:0] pins_s;
   logic scl_s;
   logic sda_s;
   logic irq_s;
   logic sup_s;
   logic drop_s;
   logic strap_low_s;
   logic strap_high_s;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic addr_match;
   logic [1:0] irq_req;
   logic [7:0] status_byte [2];

   // Pin synchronisers, bus lines idle high, supervisor active, irq held low
   pin_sync
   #(
      .W(7),
      .INIT(7'h0b)
   )
   u_sync
   (
      .clock(clock),
      .resetn(resetn),
      .clk_en(clk_en),
      .d({addr_strap_high, addr_strap_low, supply_dropout, supervisor_active,
          irq_in, sda_in, scl_in}),
      .q(pins_s)
   ); // R25

   assign scl_s = pins_s[0];
   assign sda_s = pins_s[1];
   assign irq_s = pins_s[2];
   assign sup_s = pins_s[3];
   assign drop_s = pins_s[4];
   assign strap_low_s = pins_s[5];
   assign strap_high_s = pins_s[6];

   // Per-card status blocks
   for (genvar i = 0; i < 2; i++)
   begin : g_card
      card_status u_status
      (
         .clock(clock),
         .resetn(resetn),
         .clk_en(clk_en),
         .init(sup_s),
         .read_done(st_r.read_done[i]),
         .card_in(card_in[i]),
         .status(status_byte[i]),
         .irq_req(irq_req[i])
      );
   end

   // Edges and bus conditions on synchronised lines
   assign scl_rise = scl_s & ~st_r.scl_prev; // R5
   assign scl_fall = ~scl_s & st_r.scl_prev;
   assign start_cond = scl_s & st_r.scl_prev & st_r.sda_prev & ~sda_s; // R7 R8
   assign stop_cond = scl_s & st_r.scl_prev & ~st_r.sda_prev & sda_s; // R7 R9

   // Address compare on the received byte
   assign addr_match = (st_r.shift[`CP_ADDR_PAT_HI:`CP_ADDR_PAT_LO] == `CP_ADDR_PATTERN)
      && (st_r.shift[`CP_ADDR_STRAP_HIGH_BIT] == strap_high_s)
      && (st_r.shift[`CP_ADDR_STRAP_LOW_BIT] == strap_low_s); // R17 R18

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.scl_prev = scl_s;
      st_nxt.sda_prev = sda_s;
      st_nxt.read_done = 2'b00;
      st_nxt.ctrl[0].load = 1'b0;
      st_nxt.ctrl[1].load = 1'b0;
      st_nxt.sda_out = 1'b0;
      st_nxt.irq_out = 1'b0;
      // Emergency deactivation follows the drop-out level directly
      st_nxt.emergency = drop_s; // R4
      // Open-drain interrupt: enable low pulls the line low
      st_nxt.irq_oe_n = ~(sup_s | (|irq_req)); // R1 R22

      if (sup_s)
      begin
         // Initialisation: port back to defaults
         st_nxt.state = ST_IDLE; // R3
         st_nxt.shift = 8'h00;
         st_nxt.cnt = 4'h0;
         st_nxt.card_sel = 1'b0;
         st_nxt.ack_seen = 1'b0;
         st_nxt.sda_oe_n = 1'b1;
         st_nxt.released = 1'b0;
         st_nxt.ctrl[0].control = `CP_CTRL_RESET;
         st_nxt.ctrl[1].control = `CP_CTRL_RESET;
      end
      else if (!st_r.released)
      begin
         st_nxt.sda_oe_n = 1'b1;
         if (irq_s)
            st_nxt.released = 1'b1; // R2
      end
      else if (start_cond)
      begin
         // START from any state restarts address reception
         st_nxt.state = ST_ADDR; // R8
         st_nxt.cnt = 4'h0;
         st_nxt.sda_oe_n = 1'b1;
      end
      else if (stop_cond)
      begin
         st_nxt.state = ST_IDLE; // R9
         st_nxt.sda_oe_n = 1'b1;
      end
      else
      begin
         case (st_r.state)
            ST_IDLE:
            begin
               st_nxt.sda_oe_n = 1'b1;
            end

            ST_ADDR:
            begin
               if (scl_rise)
               begin
                  st_nxt.shift = {st_r.shift[6:0], sda_s}; // R11
                  st_nxt.cnt = st_r.cnt + 4'h1;
               end
               else if (scl_fall && st_r.cnt == `CP_BITS_PER_BYTE)
               begin
                  if (addr_match)
                  begin
                     st_nxt.state = ST_ADDR_ACK;
                     st_nxt.sda_oe_n = 1'b0; // R12 R14
                     st_nxt.card_sel = st_r.shift[`CP_ADDR_CARD_BIT]; // R17
                  end
                  else
                     st_nxt.state = ST_IGNORE; // R24
               end
            end

            ST_ADDR_ACK:
            begin
               if (scl_fall)
               begin
                  st_nxt.cnt = 4'h0;
                  if (st_r.shift[`CP_ADDR_RW_BIT])
                  begin
                     // Read: first status bit goes out on this fall
                     st_nxt.state = ST_RD_DATA; // R19 R21
                     st_nxt.shift = status_byte[st_r.card_sel];
                     st_nxt.sda_oe_n = status_byte[st_r.card_sel][`CP_MSB];
                  end
                  else
                  begin
                     st_nxt.state = ST_WR_DATA; // R19 R20
                     st_nxt.sda_oe_n = 1'b1;
                  end
               end
            end

            ST_WR_DATA:
            begin
               if (scl_rise)
               begin
                  st_nxt.shift = {st_r.shift[6:0], sda_s}; // R11
                  st_nxt.cnt = st_r.cnt + 4'h1;
               end
               else if (scl_fall && st_r.cnt == `CP_BITS_PER_BYTE)
               begin
                  // Control byte to the selected card, then acknowledge
                  st_nxt.state = ST_WR_ACK;
                  st_nxt.sda_oe_n = 1'b0; // R12 R14
                  st_nxt.ctrl[st_r.card_sel].control = st_r.shift; // R20
                  st_nxt.ctrl[st_r.card_sel].load = 1'b1;
               end
            end

            ST_WR_ACK:
            begin
               if (scl_fall)
               begin
                  st_nxt.state = ST_WR_DATA;
                  st_nxt.cnt = 4'h0;
                  st_nxt.sda_oe_n = 1'b1;
               end
            end

            ST_RD_DATA:
            begin
               if (scl_rise)
                  st_nxt.cnt = st_r.cnt + 4'h1;
               else if (scl_fall)
               begin
                  if (st_r.cnt == `CP_BITS_PER_BYTE)
                  begin
                     // Byte out: release for master acknowledge
                     st_nxt.state = ST_RD_ACK;
                     st_nxt.sda_oe_n = 1'b1;
                     st_nxt.ack_seen = 1'b0;
                     st_nxt.read_done[st_r.card_sel] = 1'b1; // R22 R23
                  end
                  else
                  begin
                     st_nxt.shift = {st_r.shift[6:0], 1'b0};
                     st_nxt.sda_oe_n = st_r.shift[`CP_MSB-1];
                  end
               end
            end

            ST_RD_ACK:
            begin
               if (scl_rise)
                  st_nxt.ack_seen = ~sda_s;
               else if (scl_fall)
               begin
                  if (st_r.ack_seen)
                  begin
                     // Acknowledged: send the status byte again
                     st_nxt.state = ST_RD_DATA; // R16
                     st_nxt.cnt = 4'h0;
                     st_nxt.shift = status_byte[st_r.card_sel];
                     st_nxt.sda_oe_n = status_byte[st_r.card_sel][`CP_MSB];
                  end
                  else
                  begin
                     st_nxt.state = ST_IGNORE; // R15
                     st_nxt.sda_oe_n = 1'b1;
                  end
               end
            end

            ST_IGNORE:
            begin
               st_nxt.sda_oe_n = 1'b1; // R24
            end

            default:
            begin
               st_nxt.state = ST_IDLE;
               st_nxt.sda_oe_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= '0;
         st_r.state <= ST_IDLE;
         st_r.scl_prev <= 1'b1;
         st_r.sda_prev <= 1'b1;
         st_r.sda_oe_n <= 1'b1;
         st_r.irq_oe_n <= 1'b0;
      end
      else if (clk_en)
         st_r <= st_nxt;
   end

   assign sda_out = st_r.sda_out;
   assign sda_oe_n = st_r.sda_oe_n;
   assign irq_out = st_r.irq_out;
   assign irq_oe_n = st_r.irq_oe_n;
   assign card_ctrl = st_r.ctrl;
   assign supervisor_released = st_r.released;
   assign emergency_deact = st_r.emergency;
endmodule
`default_nettype wire

// [logic/pin_sync.sv]
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clock
// Notes: First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module pin_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic clk_en,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clock or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_r <= INIT;
         q <= INIT;
      end
      else if (clk_en)
      begin
         meta_r <= d;
         q <= meta_r;
      end
   end
endmodule
`default_nettype wire

// [pkg/cardport_map.svh]
// Purpose: Constants of the dual card two-wire control port
// Assumes: Included by the package and by the card_status and port modules
// Notes: Bit positions, address pattern, reset values and bus rates
`ifndef CARDPORT_MAP_SVH
`define CARDPORT_MAP_SVH

// Clock and bus rates
`define CP_CLOCK_HZ 25000000
`define CP_SCL_STD_HZ 100000
`define CP_SCL_FAST_HZ 400000
`define CP_SCL_FAST_PERIOD_CYC (`CP_CLOCK_HZ / `CP_SCL_FAST_HZ)

// Address byte layout
`define CP_ADDR_PATTERN 4'h4
`define CP_ADDR_PAT_HI 7
`define CP_ADDR_PAT_LO 4
`define CP_ADDR_CARD_BIT 3
`define CP_ADDR_STRAP_HIGH_BIT 2
`define CP_ADDR_STRAP_LOW_BIT 1
`define CP_ADDR_RW_BIT 0

// Byte framing
`define CP_BITS_PER_BYTE 4'h8
`define CP_MSB 7

// Status byte bit positions
`define CP_ST_PRESENT 0
`define CP_ST_PRES_CHANGE 1
`define CP_ST_IO_LEVEL 2
`define CP_ST_SUPPLY_FAULT 3
`define CP_ST_OVERLOAD 4
`define CP_ST_MUTE 5
`define CP_ST_EARLY 6
`define CP_ST_ACTIVE 7

// Reset values
`define CP_CTRL_RESET 8'h00
`define CP_STATUS_RESET 8'h00

`endif

// [pkg/cardport_pkg.sv]
// Purpose: Types of the dual card two-wire control port
// Assumes: cardport_map.svh holds the numbers
// Notes: Card inputs come from same-clock sequencer logic
`default_nettype none
package cardport_pkg;
`include "cardport_map.svh"

   // Per-card inputs from the sequencers and card contacts
   typedef struct packed
   {
      logic present;
      logic io_level;
      logic active;
      logic mute_evt;
      logic early_evt;
      logic overload_evt;
   } card_in_s;

   // Per-card control byte towards the sequencers
   typedef struct packed
   {
      logic [7:0] control;
      logic load;
   } ctrl_out_s;

   typedef enum logic [2:0]
   {
      ST_IDLE,
      ST_ADDR,
      ST_ADDR_ACK,
      ST_WR_DATA,
      ST_WR_ACK,
      ST_RD_DATA,
      ST_RD_ACK,
      ST_IGNORE
   } i2c_state_e;

   // State of one card status block
   typedef struct packed
   {
      logic pres_prev;
      logic presence_change_flag;
      logic supply_fault_flag;
      logic overload_flag;
      logic mute_flag;
      logic early_flag;
      logic [7:0] status;
      logic irq_req;
   } card_state_s;

   // State of the port
   typedef struct packed
   {
      i2c_state_e state;
      logic [7:0] shift;
      logic [3:0] cnt;
      logic card_sel;
      logic ack_seen;
      logic scl_prev;
      logic sda_prev;
      logic sda_out;
      logic sda_oe_n;
      logic irq_out;
      logic irq_oe_n;
      logic released;
      logic emergency;
      logic [1:0] read_done;
      ctrl_out_s [1:0] ctrl;
   } port_state_s;

endpackage
`default_nettype wire

// [testbench/dual_card_i2c_control_port_tb_top.sv]
// Purpose: Self-checking bench of the two-wire card port
// Assumes: Host model drives SCL and SDA
// Notes: Control inputs change on the rising clock edge
`timescale 1ns/10ps
`default_nettype none
module dual_card_i2c_control_port_tb_top;
   import cardport_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic sup = 1'b1;
   logic drop = 1'b0;
   logic s_lo = 1'b0;
   logic s_hi = 1'b0;
   card_in_s [1:0] cin;
   ctrl_out_s [1:0] cc;
   logic scl, sda_drv, sda_out, sda_oe_n, irq_out, irq_oe_n, rel, emg;
   wire logic sda = sda_drv & (sda_oe_n | sda_out);
   wire logic irq = irq_oe_n | irq_out;
   int mismatches = 0;
   int cmp_count = 0;
   initial
   begin
      forever #20 clock = ~clock;
   end
   dual_card_i2c_port dut_u
   (
      .clock(clock), .resetn(resetn), .clk_en(1'b1), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq_in(irq), .irq_out(irq_out),
      .irq_oe_n(irq_oe_n), .addr_strap_low(s_lo), .addr_strap_high(s_hi),
      .supervisor_active(sup), .supply_dropout(drop), .card_in(cin), .card_ctrl(cc),
      .supervisor_released(rel), .emergency_deact(emg)
   );
   host_model host_u (.scl(scl), .sda_drv(sda_drv), .sda(sda));
   task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
      cmp_count++;
      if (s !== e)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test();
      if (mismatches == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wait_rel();
      for (int i = 0; i < 200 && rel !== 1'b1; i++)
         @(posedge clock);
      check("released", 8'(rel), 8'h01);
      if (rel !== 1'b1)
         stop_test();
   endtask
   task automatic wr_tx(input logic [7:0] a, input logic [7:0] d, input logic ok);
      logic k;
      host_u.start();
      host_u.wr(a, k);
      check("addr ack", 8'(k), 8'(ok));
      host_u.wr(d, k);
      check("data ack", 8'(k), 8'(ok));
      host_u.stop();
      cyc(1);
   endtask
   task automatic rd_tx(input logic [7:0] a, input logic [7:0] e);
      logic k;
      logic [7:0] d;
      host_u.start();
      host_u.wr(a, k);
      check("read ack", 8'(k), 8'h01);
      host_u.rd(1'b0, d);
      check("status", d, e);
      host_u.stop();
      cyc(6);
      check("irq free", 8'(irq), 8'h01);
   endtask
   task automatic t_power();
      logic k;
      logic [7:0] d;
      cyc(4);
      check("irq sup", 8'(irq), 8'h00);
      wr_tx(8'h40, 8'h11, 1'b0);
      sup <= 1'b0;
      wait_rel();
      check("irq up", 8'(irq), 8'h01);
      host_u.start();
      host_u.wr(8'h41, k);
      check("addr ack 1", 8'(k), 8'h01);
      host_u.rd(1'b1, d);
      check("status 1", d, 8'h0c);
      host_u.rd(1'b0, d);
      check("status 2", d, 8'h04);
      host_u.stop();
      cyc(1);
   endtask
   task automatic t_write();
      logic [7:0] a;
      for (int s = 0; s < 4; s++)
         for (int c = 0; c < 2; c++)
         begin
            a = {4'h4, c[0], s[1:0], 1'b0};
            s_hi <= s[1];
            s_lo <= s[0];
            cyc(4);
            wr_tx(a, a ^ 8'h9c, 1'b1);
            check("ctrl", cc[c].control, a ^ 8'h9c);
         end
      wr_tx(8'h40, 8'h33, 1'b0);
      wr_tx(8'h5e, 8'h33, 1'b0);
      check("ctrl kept", cc[1].control, 8'h4e ^ 8'h9c);
      s_hi <= 1'b0;
      s_lo <= 1'b0;
      cyc(4);
   endtask
   task automatic t_events();
      logic [7:0] ex [4] = '{8'h24, 8'h44, 8'h14, 8'h07};
      for (int k = 0; k < 4; k++)
      begin
         case (k)
            0: cin[0].mute_evt <= 1'b1;
            1: cin[0].early_evt <= 1'b1;
            2: cin[0].overload_evt <= 1'b1;
            default: cin[0].present <= 1'b1;
         endcase
         @(posedge clock);
         cin[0].mute_evt <= 1'b0;
         cin[0].early_evt <= 1'b0;
         cin[0].overload_evt <= 1'b0;
         cyc(4);
         check("irq evt", 8'(irq), 8'h00);
         rd_tx(8'h41, ex[k]);
      end
   endtask
   task automatic t_restart();
      logic r;
      host_u.start();
      for (int i = 0; i < 4; i++)
         host_u.bit_x(i == 1, r);
      wr_tx(8'h48, 8'ha5, 1'b1);
      check("restart", cc[1].control, 8'ha5);
   endtask
   task automatic t_rate();
      int hs [2] = '{5000, 1250};
      for (int i = 0; i < 2; i++)
      begin
         host_u.half = hs[i];
         wr_tx(8'h40, 8'h3c + i[7:0], 1'b1);
         check("rate ctrl", cc[0].control, 8'h3c + i[7:0]);
      end
      host_u.half = 160;
   endtask
   task automatic t_reinit();
      sup <= 1'b1;
      cyc(6);
      check("irq init", 8'(irq), 8'h00);
      check("ctrl init", cc[0].control, 8'h00);
      check("rel init", 8'(rel), 8'h00);
      sup <= 1'b0;
      wait_rel();
      rd_tx(8'h49, 8'h88);
      drop <= 1'b1;
      cyc(5);
      check("emerg on", 8'(emg), 8'h01);
      drop <= 1'b0;
      cyc(5);
      check("emerg off", 8'(emg), 8'h00);
   endtask
   initial
   begin
      cin[0] = 6'b010000;
      cin[1] = 6'b001000;
      cyc(2);
      resetn <= 1'b1;
      t_power();
      t_write();
      t_events();
      t_restart();
      t_rate();
      t_reinit();
      stop_test();
   end
endmodule
`default_nettype wire

// [testbench/dual_card_i2c_port_checker.sv]
// Purpose: Port checker of the two-wire card port
// Assumes: Bound to the top design module
// Notes: Pin inputs lag two clocks plus one register
`timescale 1ns/10ps
`default_nettype none
module dual_card_i2c_port_checker
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_oe_n,
   input wire logic irq_in,
   input wire logic irq_oe_n,
   input wire logic supervisor_active,
   input wire logic supply_dropout,
   input wire cardport_pkg::card_in_s [1:0] card_in,
   input wire cardport_pkg::ctrl_out_s [1:0] card_ctrl,
   input wire logic supervisor_released,
   input wire logic emergency_deact
);
   import cardport_pkg::*;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);
   wire logic evt = |{card_in[0].mute_evt, card_in[0].early_evt, card_in[0].overload_evt,
      card_in[1].mute_evt, card_in[1].early_evt, card_in[1].overload_evt};
   wire logic load = card_ctrl[0].load | card_ctrl[1].load;
   sequence sup_held_s;
      supervisor_active [*4];
   endsequence
   sequence stop_s;
      scl_in && $rose(sda_in);
   endsequence
   sup_irq_a: assert property (sup_held_s |-> !irq_oe_n)
      else $error("irq line not held low by supervisor");
   sup_init_a: assert property (sup_held_s |-> !supervisor_released && card_ctrl == '0)
      else $error("state not returned to defaults");
   rel_cause_a: assert property ($rose(supervisor_released) |->
      $past(irq_in, 3) && !$past(supervisor_active, 3))
      else $error("released without irq line high");
   idle_refuse_a: assert property (!supervisor_released |-> sda_oe_n)
      else $error("sda driven before release");
   ack_hold_a: assert property (scl_in && $past(scl_in) && $past(scl_in, 2) |->
      $stable(sda_oe_n))
      else $error("sda drive changed while scl high");
   stop_free_a: assert property (stop_s |-> sda_oe_n [*4])
      else $error("sda driven after stop");
   load_pulse_a: assert property (load |=> !load)
      else $error("control load longer than one cycle");
   load_ack_a: assert property (load |-> ##[0:1] !sda_oe_n)
      else $error("control load without acknowledge");
   irq_evt_a: assert property (supervisor_released && evt |-> ##[1:3] !irq_oe_n)
      else $error("event did not pull irq low");
   emerg_on_a: assert property ($rose(supply_dropout) |-> ##[1:3] emergency_deact)
      else $error("no emergency deactivation");
   emerg_off_a: assert property ($fell(supply_dropout) |-> ##[1:3] !emergency_deact)
      else $error("emergency deactivation stuck");
endmodule
bind dual_card_i2c_port dual_card_i2c_port_checker chk_u
(
   .clock(clock), .resetn(resetn), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
   .irq_in(irq_in), .irq_oe_n(irq_oe_n), .supervisor_active(supervisor_active),
   .supply_dropout(supply_dropout), .card_in(card_in), .card_ctrl(card_ctrl),
   .supervisor_released(supervisor_released), .emergency_deact(emergency_deact)
);
`default_nettype wire

// [testbench/host_model.sv]
// Purpose: Two-wire bus master model
// Assumes: Lines pulled up; sda is the wired level
// Notes: half is the SCL half period in ns; SCL idles high
`timescale 1ns/10ps
`default_nettype none
module host_model
(
   output logic scl,
   output logic sda_drv,
   input wire logic sda
);
   int half = 160;
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic start();
      sda_drv = 1'b1;
      #(half / 2) scl = 1'b1;
      #(half) sda_drv = 1'b0;
      #(half) scl = 1'b0;
   endtask
   task automatic bit_x(input logic b, output logic r);
      #(half / 4) sda_drv = b;
      #(half * 3 / 4) scl = 1'b1;
      #(half / 2) r = sda;
      #(half / 2) scl = 1'b0;
   endtask
   task automatic stop();
      #(half / 4) sda_drv = 1'b0;
      #(half * 3 / 4) scl = 1'b1;
      #(half) sda_drv = 1'b1;
      #(half);
   endtask
   task automatic wr(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask
   task automatic rd(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_x(1'b1, d[i]);
      bit_x(~ack, r);
   endtask
endmodule
`default_nettype wire
